// *** hw/spms_pkg.sv ***
// Package with constants, register map and state type of the sleep and power-mode sequencer.
package spms_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_MHZ      = 250;
    localparam int CLK_NS       = 4;
    localparam int OSC_WAIT_US  = 700;
    localparam int OSC_WAIT_CYC = OSC_WAIT_US * CLK_MHZ;
    localparam int DIG_RST_NS   = 100;
    localparam int DIG_RST_CYC  = (DIG_RST_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [6:0] DOZE_DIV_LAST = 7'h7f;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_WAKE = 8'h04;
    localparam logic [7:0] OFS_PSC  = 8'h08;
    localparam logic [7:0] OFS_TMR  = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;

    // ************************************************************
    // Control, wake and status fields
    // ************************************************************
    localparam int CTRL_W    = 11;
    localparam int B_HIB     = 0;
    localparam int B_DOZE    = 1;
    localparam int B_LRET    = 2;
    localparam int B_PRET    = 3;
    localparam int B_X32     = 4;
    localparam int B_AUTO    = 5;
    localparam int B_RAM     = 6;
    localparam int B_HWK     = 9;
    localparam int B_MODEM   = 10;
    localparam int WAKE_W    = 12;
    localparam int B_MASK    = 0;
    localparam int B_POL     = 4;
    localparam int B_LVL     = 8;
    localparam int B_SYNC    = 0;
    localparam int B_SRC     = 8;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [10:0] CTRL_RST = 11'h000;
    localparam logic [11:0] WAKE_RST = 12'hff0;
    localparam logic [5:0]  PSC_RST  = 6'h00;
    localparam logic [15:0] CMP_RST  = 16'h0000;
    localparam logic [3:0]  KOUT_RST = 4'hf;

    // ************************************************************
    // Bus answers and states
    // ************************************************************
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        S_OSC,
        S_SUPPLY,
        S_DIGRST,
        S_RUN,
        S_SYNCW,
        S_SYNCS,
        S_SLEEP
    } spms_state_type;

endpackage

// *** hw/spms_sync.sv ***
// Two-flop synchroniser for pins and slow oscillators entering the aclk domain.
`timescale 1ns/1ps
module spms_sync #(
    parameter int W = 6
) (
    // Clock and reset.
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Data.
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } spms_sync_type;

    spms_sync_type q;
    spms_sync_type d;

    always_comb
    begin
        d    = q;
        d.s1 = async_in;
        d.s2 = q.s1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign sync_out = q.s2;

endmodule // spms_sync

// *** hw/spms_top.sv ***
// Sleep and power-mode sequencer with AXI4-Lite register access.
`timescale 1ns/1ps
module spms_top #(
    parameter int OSC_CYC = spms_pkg::OSC_WAIT_CYC
) (
    // Clock and reset.
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // AXI4-Lite slave.
    input  wire logic [7:0] s_axi_awaddr,
    input  wire logic       s_axi_awvalid,
    output logic            s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0] s_axi_wstrb,
    input  wire logic       s_axi_wvalid,
    output logic            s_axi_wready,
    output logic [1:0]      s_axi_bresp,
    output logic            s_axi_bvalid,
    input  wire logic       s_axi_bready,
    input  wire logic [7:0] s_axi_araddr,
    input  wire logic       s_axi_arvalid,
    output logic            s_axi_arready,
    output logic [31:0]     s_axi_rdata,
    output logic [1:0]      s_axi_rresp,
    output logic            s_axi_rvalid,
    input  wire logic       s_axi_rready,
    // Oscillators and timer events.
    input  wire logic       ring_osc_in,
    input  wire logic       xtal32_osc_in,
    input  wire logic       rtc_timeout_pulse,
    // Keypad pins.
    input  wire logic [3:0] keypad_wake_in_pins,
    output logic [3:0]      keypad_wake_pull_up,
    output logic [3:0]      keypad_wake_pull_down,
    output logic [2:0]      keypad_out_pins,
    output logic [2:0]      keypad_out_oe,
    output logic            host_wake_out_pin,
    output logic            host_wake_oe,
    output logic            keypad_sleep_ctrl,
    // Power and clock controls.
    output logic            ref_osc_en,
    output logic            dig_supply_en,
    output logic            dig_reset_n,
    output logic            core_clk_en,
    output logic            core_clk_tick,
    output logic            modem_clk_en,
    output logic [1:0]      sleep_clk_sel,
    output logic [3:0]      ram_page_pwr,
    output logic            ram_retain_lv,
    output logic            ram_access_en,
    output logic            logic_retain_out,
    output logic            pad_power_en,
    output logic            auto_conv_en
);
    import spms_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        spms_state_type st;
        logic [17:0]    cnt;
        logic [6:0]     div;
        logic [5:0]     pre;
        logic           ro_prev;
        logic           x32_prev;
        logic [15:0]    tmr;
        logic           deep_sleep_request;
        logic           keep;
        logic [10:0]    ctrl;
        logic [11:0]    wctl;
        logic [5:0]     psc;
        logic [15:0]    cmp;
        logic           sync;
        logic [7:0]     src;
        logic [3:0]     kout;
        logic           aw_v;
        logic [7:0]     aw_a;
        logic           w_v;
        logic [31:0]    w_d;
        logic [3:0]     w_s;
        logic           b_v;
        logic [1:0]     b_r;
        logic           r_v;
        logic [1:0]     r_r;
        logic [31:0]    r_d;
    } spms_regs_type;

    spms_regs_type q;
    spms_regs_type d;
    logic [5:0]    sy;
    logic [3:0]    act;
    logic          low_pwr;

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++)
        begin
            if (s[i])
            begin
                r[8*i +: 8] = n[8*i +: 8];
            end
        end
        return r;
    endfunction

    spms_sync #(
        .W (6)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({xtal32_osc_in, ring_osc_in, keypad_wake_in_pins}),
        .sync_out (sy)
    );

    assign act = ~(sy[3:0] ^ q.wctl[B_POL +: 4]);
    assign low_pwr = (q.st == S_OSC) || (q.st == S_SUPPLY) || (q.st == S_DIGRST) || (q.st == S_SLEEP);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        logic [7:0]  wa;
        logic [7:0]  ra;
        logic [31:0] m;
        logic        wr;
        logic        tick;
        logic        tmr_hit;
        logic [3:0]  ext;
        logic        sync_clr;
        d        = q;
        wa       = {q.aw_a[7:2], 2'h0};
        ra       = {s_axi_araddr[7:2], 2'h0};
        m        = '0;
        wr       = q.aw_v && q.w_v && !q.b_v;
        sync_clr = 1'b0;
        tick     = 1'b0;
        tmr_hit  = 1'b0;
        ext      = 4'h0;
        if (s_axi_awvalid && !q.aw_v)
        begin
            d.aw_v = 1'b1;
            d.aw_a = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.w_v)
        begin
            d.w_v = 1'b1;
            d.w_d = s_axi_wdata;
            d.w_s = s_axi_wstrb;
        end
        if (q.b_v && s_axi_bready)
        begin
            d.b_v = 1'b0;
        end
        if (q.r_v && s_axi_rready)
        begin
            d.r_v = 1'b0;
        end
        if (s_axi_arvalid && !q.r_v)
        begin
            d.r_v = 1'b1;
            d.r_r = RESP_OKAY;
            d.r_d = '0;
            case (ra)
                OFS_CTRL: d.r_d[CTRL_W-1:0] = q.ctrl;
                OFS_WAKE: d.r_d[WAKE_W-1:0] = q.wctl;
                OFS_PSC:  d.r_d[5:0] = q.psc;
                OFS_TMR:  d.r_d = {q.tmr, q.cmp};
                OFS_STAT: d.r_d = {13'h0000, q.st, q.src, 7'h00, q.sync};
                default:  d.r_r = RESP_SLVERR;
            endcase
        end
        if (wr)
        begin
            d.aw_v = 1'b0;
            d.w_v  = 1'b0;
            d.b_v  = 1'b1;
            d.b_r  = RESP_OKAY;
            case (wa)
                OFS_CTRL:
                begin
                    m      = merge({21'h000000, q.ctrl}, q.w_d, q.w_s);
                    d.ctrl = m[CTRL_W-1:0];
                end
                OFS_WAKE:
                begin
                    m      = merge({20'h00000, q.wctl}, q.w_d, q.w_s);
                    d.wctl = m[WAKE_W-1:0];
                end
                OFS_PSC:
                begin
                    m     = merge({26'h0000000, q.psc}, q.w_d, q.w_s);
                    d.psc = m[5:0];
                end
                OFS_TMR:
                begin
                    m     = merge({16'h0000, q.cmp}, q.w_d, q.w_s);
                    d.cmp = m[15:0];
                end
                OFS_STAT:
                begin
                    m        = q.w_d & {{8{q.w_s[3]}}, {8{q.w_s[2]}}, {8{q.w_s[1]}}, {8{q.w_s[0]}}};
                    sync_clr = m[B_SYNC] && q.sync;
                    d.src    = q.src & ~m[B_SRC +: 8];
                    if (sync_clr)
                    begin
                        d.sync = 1'b0;
                    end
                end
                default: d.b_r = RESP_SLVERR;
            endcase
        end

        d.ro_prev  = sy[4];
        d.x32_prev = sy[5];
        d.div      = q.div + 7'h01;
        if (q.deep_sleep_request)
        begin
            tick = q.ctrl[B_X32] ? (sy[5] && !q.x32_prev) : (sy[4] && !q.ro_prev);
        end
        else
        begin
            tick = (q.div == DOZE_DIV_LAST);
        end
        tmr_hit = (q.cmp != CMP_RST) && (q.tmr == q.cmp);
        ext     = act & q.wctl[B_MASK +: 4];

        if (core_clk_en)
        begin
            d.pre = (q.pre == q.psc) ? 6'h00 : q.pre + 6'h01;
        end
        else
        begin
            d.pre = 6'h00;
        end

        // Power sequencing and sleep control.
        case (q.st)
            S_OSC:
            begin
                d.cnt = q.cnt + 18'h00001;
                if (q.cnt == 18'(OSC_CYC - 1))
                begin
                    d.cnt = '0;
                    d.st  = S_SUPPLY;
                end
            end
            S_SUPPLY:
            begin
                d.st = q.keep ? S_RUN : S_DIGRST;
            end
            S_DIGRST:
            begin
                d.cnt = q.cnt + 18'h00001;
                if (q.cnt == 18'(DIG_RST_CYC - 1))
                begin
                    d.cnt = '0;
                    d.st  = S_RUN;
                end
            end
            S_RUN:
            begin
                d.keep = 1'b0;
                if (q.ctrl[B_HIB] || q.ctrl[B_DOZE])
                begin
                    d.deep_sleep_request = q.ctrl[B_HIB];
                    d.st  = S_SYNCW;
                end
            end
            S_SYNCW:
            begin
                if (tick)
                begin
                    d.sync = 1'b1;
                    d.st   = S_SYNCS;
                end
            end
            S_SYNCS:
            begin
                if (sync_clr)
                begin
                    d.st           = S_SLEEP;
                    d.tmr          = '0;
                    d.ctrl[B_HIB]  = 1'b0;
                    d.ctrl[B_DOZE] = 1'b0;
                    d.keep         = q.ctrl[B_LRET];
                end
            end
            S_SLEEP:
            begin
                if (tick && !tmr_hit)
                begin
                    d.tmr = q.tmr + 16'h0001;
                end
                if ((|ext) || tmr_hit || rtc_timeout_pulse)
                begin
                    d.src = d.src | {!q.deep_sleep_request, q.deep_sleep_request, rtc_timeout_pulse, tmr_hit, ext};
                    d.st  = q.deep_sleep_request ? S_OSC : S_SUPPLY;
                end
            end
            default:
            begin
                d.st = S_OSC;
            end
        endcase

        if ((d.st != S_RUN) && (d.st != S_SYNCW) && (d.st != S_SYNCS))
        begin
            d.kout = {q.wctl[B_LVL+1 +: 3], q.ctrl[B_HWK] ? (d.st != S_SLEEP) : q.wctl[B_LVL]};
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q      <= '0;
            q.st   <= S_OSC;
            q.ctrl <= CTRL_RST;
            q.wctl <= WAKE_RST;
            q.psc  <= PSC_RST;
            q.cmp  <= CMP_RST;
            q.kout <= KOUT_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign s_axi_awready = !q.aw_v;
    assign s_axi_wready  = !q.w_v;
    assign s_axi_bvalid  = q.b_v;
    assign s_axi_bresp   = q.b_r;
    assign s_axi_arready = !q.r_v;
    assign s_axi_rvalid  = q.r_v;
    assign s_axi_rdata   = q.r_d;
    assign s_axi_rresp   = q.r_r;

    assign keypad_sleep_ctrl     = low_pwr;
    assign keypad_out_oe         = {3{low_pwr}};
    assign host_wake_oe          = low_pwr;
    assign keypad_out_pins       = q.kout[3:1];
    assign host_wake_out_pin     = q.kout[0];
    assign keypad_wake_pull_up   = low_pwr ? ~q.wctl[B_POL +: 4] : 4'h0;
    assign keypad_wake_pull_down = low_pwr ? q.wctl[B_POL +: 4] : 4'h0;

    assign ref_osc_en    = !((q.st == S_SLEEP) && q.deep_sleep_request);
    assign dig_supply_en = (q.st != S_OSC) && (q.st != S_SLEEP);
    assign dig_reset_n   = !((q.st == S_DIGRST) || (low_pwr && !q.keep));
    assign core_clk_en   = (q.st == S_RUN) || (q.st == S_SYNCW) || (q.st == S_SYNCS);
    assign core_clk_tick = core_clk_en && (q.pre == q.psc);
    assign modem_clk_en  = core_clk_en && q.ctrl[B_MODEM];
    assign sleep_clk_sel = !q.deep_sleep_request ? 2'h0 : (q.ctrl[B_X32] ? 2'h2 : 2'h1);
    assign ram_page_pwr  = (q.st == S_SLEEP) ? {q.ctrl[B_RAM +: 3], 1'b1} : {4{dig_supply_en}};
    assign ram_retain_lv = (q.st == S_SLEEP);
    assign ram_access_en = core_clk_en;
    assign logic_retain_out = (q.st == S_SLEEP) && q.ctrl[B_LRET];
    assign pad_power_en  = (q.st == S_SLEEP) ? (q.ctrl[B_LRET] && q.ctrl[B_PRET]) : dig_supply_en;
    assign auto_conv_en  = (q.st == S_SLEEP) && q.deep_sleep_request && q.ctrl[B_AUTO];

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_supply_after_osc: assert property ($rose(dig_supply_en) |-> $past(q.cnt) == 18'(OSC_CYC - 1)
        || ($past(q.st) == S_SLEEP && !q.deep_sleep_request))
        else $error("Supply enabled before oscillator wait ended");
    a_gate_order: assert property ($rose(core_clk_en) |-> dig_reset_n && dig_supply_en && ref_osc_en)
        else $error("Core clock gated before supply and reset done");
    a_prescale_two: assert property ((core_clk_tick && q.psc == 6'h01) ##1 (core_clk_en && q.psc == 6'h01)
        |-> !core_clk_tick ##1 (!core_clk_en || core_clk_tick))
        else $error("Prescaler ratio two not kept");
    a_idle_modem_off: assert property (!q.ctrl[B_MODEM] |-> !modem_clk_en)
        else $error("Modem clock on in idle");
    a_doze_div: assert property ($rose(q.sync) && !q.deep_sleep_request |-> $past(q.div) == DOZE_DIV_LAST)
        else $error("Doze sync not on divide by 128 tick");
    a_sleep_power: assert property (q.st == S_SLEEP |-> !dig_supply_en && ram_page_pwr[0] && !core_clk_en)
        else $error("Sleep power state wrong");
    a_ram_no_access: assert property (ram_retain_lv |-> !ram_access_en)
        else $error("Retained RAM accessible");
    a_pad_ignore: assert property (q.st == S_SLEEP && !q.ctrl[B_LRET] |-> !pad_power_en)
        else $error("Pads powered without logic retention");
    a_keypad_dir: assert property (low_pwr |-> keypad_out_oe == 3'h7 && host_wake_oe)
        else $error("Keypad outputs not driven in low power");
    a_no_auto_doze: assert property (auto_conv_en |-> q.deep_sleep_request)
        else $error("Converter running in doze");
    a_host_wake_rise: assert property ($past(q.st) == S_SLEEP && q.st != S_SLEEP && q.ctrl[B_HWK]
        |-> host_wake_out_pin && !$past(host_wake_out_pin))
        else $error("Host wake pin did not rise at wake");
    a_wake_pin_low: assert property (q.st == S_SLEEP && q.ctrl[B_HWK] |-> !host_wake_out_pin)
        else $error("Host wake pin high during sleep");
    a_mask_gate: assert property (q.st == S_SLEEP && (act & q.wctl[3:0]) == 4'h0 && !rtc_timeout_pulse
        && (q.cmp == CMP_RST || q.tmr != q.cmp) |=> q.st == S_SLEEP)
        else $error("Woke without an enabled source");
    a_sync_down: assert property ($rose(q.st == S_SLEEP) |-> $past(q.sync) && !q.sync)
        else $error("Sync flag missing before power down");

    c_por_run: cover property (q.st == S_DIGRST ##1 q.st == S_RUN);
    c_hib_wake: cover property (q.st == S_SLEEP && q.deep_sleep_request ##1 q.st == S_OSC);
    c_doze_wake: cover property (q.st == S_SLEEP && !q.deep_sleep_request ##1 q.st == S_SUPPLY);
    c_multi_wake: cover property (q.st == S_SLEEP ##1 $countones(q.src[5:0]) > 1);

endmodule // spms_top

// *** verif/spms_far_end.sv ***
// Far-side model: wake pins, ring oscillator and timer pulse.
`timescale 1ns/1ps
module spms_far_end (
    // Commands.
    input  wire logic       aclk,
    input  wire logic [3:0] pin_val,
    input  wire logic       rtc_fire,
    // Device pins.
    output logic [3:0]      keypad_wake_in_pins,
    output logic            ring_osc_in,
    output logic            xtal32_osc_in,
    output logic            rtc_timeout_pulse
);
    assign keypad_wake_in_pins = pin_val;
    always @(posedge aclk) rtc_timeout_pulse <= rtc_fire;
    initial
    begin
        ring_osc_in = 1'b0;
        forever #26 ring_osc_in = ~ring_osc_in;
    end
    initial
    begin
        xtal32_osc_in = 1'b0;
        forever #10 xtal32_osc_in = ~xtal32_osc_in;
    end
endmodule // spms_far_end

// *** verif/spms_top_tb.sv ***
// Self-checking bench of the sleep and power-mode sequencer.
`timescale 1ns/1ps
module spms_top_tb;
    import spms_pkg::*;
    logic aclk, aresetn, rtc_fire, ring_osc_in, xtal32_osc_in, rtc_timeout_pulse;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic host_wake_out_pin, host_wake_oe, keypad_sleep_ctrl, ref_osc_en, dig_supply_en, dig_reset_n, core_clk_en;
    logic core_clk_tick, modem_clk_en, ram_retain_lv, ram_access_en, auto_conv_en, logic_retain_out, pad_power_en;
    logic [1:0] s_axi_bresp, s_axi_rresp, sleep_clk_sel, r;
    logic [2:0] keypad_out_pins, keypad_out_oe;
    logic [3:0] s_axi_wstrb, pin_val, keypad_wake_in_pins, keypad_wake_pull_up, keypad_wake_pull_down;
    logic [3:0] ram_page_pwr, pol, m;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [5:0] psc;
    int num_errors, cmp_count, p, src_model;
    spms_top #(.OSC_CYC(20)) dut (.*);
    spms_far_end far (.*);
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (num_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic quit();
        num_errors++;
        give_verdict();
    endtask
    task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            k++;
            if (k > 3000) quit();
        end while (!(w ? s_axi_bvalid : s_axi_rvalid));
        {rd, r} = w ? {32'h0, s_axi_bresp} : {s_axi_rdata, s_axi_rresp};
        {s_axi_bready, s_axi_rready} <= 2'b00;
    endtask
    task automatic enter_sleep();
        int k;
        do
        begin
            axi(0, OFS_STAT, 0);
            k++;
            if (k > 300) quit();
        end while (!rd[0]);
        axi(1, OFS_STAT, 32'h1);
    endtask
    task automatic wait_run(input int min_s, input int min_gap, input logic lo_exp);
        int k, s;
        logic lo;
        lo = 1'b0;
        do
        begin
            @(negedge aclk);
            k++;
            lo |= !dig_reset_n;
            if (dig_supply_en && s == 0) s = k;
            if (k > 3000) quit();
        end while (!core_clk_en);
        chk({s >= min_s, k - s >= min_gap, lo, dig_supply_en, dig_reset_n, ref_osc_en, modem_clk_en, ram_access_en},
            {2'b11, lo_exp, 5'b11101});
    endtask
    initial
    begin
        void'($urandom(52442));
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, rtc_fire} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pin_val} = '0;
        s_axi_wstrb = 4'hf;
        repeat (6) @(posedge aclk);
        @(negedge aclk);
        chk({ref_osc_en, dig_supply_en, dig_reset_n, core_clk_en}, 4'h8);
        chk({keypad_out_oe, host_wake_oe, keypad_wake_pull_down, keypad_wake_pull_up}, 12'hff0);
        @(posedge aclk);
        aresetn <= 1'b1;
        wait_run(20, DIG_RST_CYC, 1);
        axi(1, 8'h14, 0);
        chk(r, RESP_SLVERR);
        psc = $urandom;
        axi(1, OFS_PSC, {26'h0, psc});
        for (p = 0; p < 99 && !core_clk_tick; p++) @(negedge aclk);
        @(negedge aclk);
        for (p = 1; p < 99 && !core_clk_tick; p++) @(negedge aclk);
        chk(p, psc + 1);
        p = $urandom_range(3);
        pol = $urandom;
        m = 4'h1 << p;
        pin_val <= ~pol;
        axi(1, OFS_WAKE, {20'hf, pol, m});
        axi(1, OFS_CTRL, 32'h22a);
        enter_sleep();
        @(negedge aclk);
        chk({dig_supply_en, ref_osc_en, sleep_clk_sel, ram_retain_lv, ram_access_en}, 6'h12);
        chk({ram_page_pwr, pad_power_en, auto_conv_en, logic_retain_out}, 7'h08);
        chk({keypad_sleep_ctrl, keypad_out_oe, host_wake_oe, keypad_out_pins, host_wake_out_pin}, 9'h1fe);
        chk({keypad_wake_pull_up, keypad_wake_pull_down}, {~pol, pol});
        @(posedge aclk);
        pin_val <= pol ^ m;
        repeat (20) @(posedge aclk);
        chk(dig_supply_en, 1'b0);
        pin_val <= pol;
        wait_run(1, DIG_RST_CYC, 1);
        chk({keypad_out_oe, host_wake_out_pin}, 4'h1);
        axi(0, OFS_STAT, 0);
        src_model = (32'h100 << p) | 32'h8000;
        chk(rd & 32'h7ffff, src_model | 32'h30000);
        pin_val <= ~pol;
        axi(1, OFS_WAKE, {20'hf, pol, 4'h0});
        axi(1, OFS_CTRL, 32'h1ed);
        enter_sleep();
        @(negedge aclk);
        chk({ref_osc_en, sleep_clk_sel, auto_conv_en, logic_retain_out, pad_power_en, ram_page_pwr, dig_reset_n},
            11'h1ff);
        @(posedge aclk);
        rtc_fire <= 1'b1;
        @(posedge aclk);
        rtc_fire <= 1'b0;
        wait_run(20, 0, 0);
        axi(0, OFS_STAT, 0);
        src_model |= 32'h6000;
        chk(rd & 32'h7ffff, src_model | 32'h30000);
        axi(1, OFS_TMR, 32'h3);
        axi(1, OFS_CTRL, 32'h19);
        enter_sleep();
        @(negedge aclk);
        chk({sleep_clk_sel, ref_osc_en, logic_retain_out, pad_power_en, ram_page_pwr}, 9'h101);
        wait_run(20, DIG_RST_CYC, 1);
        src_model |= 32'h5000;
        axi(0, OFS_STAT, 0);
        chk(rd & 32'h7ffff, src_model | 32'h30000);
        axi(0, OFS_TMR, 0);
        chk(rd, 32'h00030003);
        give_verdict();
    end
endmodule // spms_top_tb
